// ===== logic/byte_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
   parameter int unsigned WIDTH = 18,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             clk_sys,
   input  wire logic             sys_rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int unsigned PTR_W = $clog2(DEPTH);
   localparam int unsigned CNT_W = $clog2(DEPTH + 1);
   localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
   localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

   logic [WIDTH-1:0] store [0:DEPTH-1];
   logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next;
   logic [PTR_W-1:0] rd_ptr_reg, rd_ptr_next;
   logic [CNT_W-1:0] count_reg, count_next;
   logic             do_wr;
   logic             do_rd;

   assign in_ready  = (count_reg != FULL_CNT);
   assign out_valid = (count_reg != '0);
   assign out_data  = store[rd_ptr_reg];

   // Pointer and fill-level update; pointers wrap for any depth
   always_comb begin
      do_wr       = in_valid && in_ready;
      do_rd       = out_valid && out_ready;
      wr_ptr_next = wr_ptr_reg;
      rd_ptr_next = rd_ptr_reg;
      count_next  = count_reg;
      if (do_wr) begin
         wr_ptr_next = (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
         rd_ptr_next = (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (do_wr && !do_rd) begin
         count_next = count_reg + 1'b1;
      end else if (do_rd && !do_wr) begin
         count_next = count_reg - 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         count_reg  <= count_next;
      end
   end

   // Storage needs no reset; entries are only read once written
   always_ff @(posedge clk_sys) begin
      if (do_wr) begin
         store[wr_ptr_reg] <= in_data;
      end
   end
endmodule

// ===== logic/eeprom_pkg.sv
// Shared constants and types for the two-wire serial memory slave
package eeprom_pkg;
   // Core clock
   localparam int unsigned CLK_NS     = 10;
   // Glitch filter: a level must hold this long before it is believed
   localparam int unsigned GLITCH_NS  = 30;
   localparam int unsigned GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned FILT_W     = 4;
   // Self-timed programming cycle
   localparam int unsigned PROG_MS    = 5;
   localparam int unsigned PROG_CYC   = PROG_MS * 1000000 / CLK_NS;
   localparam int unsigned PROG_W     = 20;
   // Array geometry
   localparam int unsigned BYTE_W     = 8;
   localparam int unsigned ADDR_W     = 10;
   localparam int unsigned PAGE_W     = 4;
   localparam int unsigned PAGE_BYTES = 16;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam int unsigned FIFO_W     = ADDR_W + BYTE_W;
   localparam int unsigned BIT_CNT_W  = 4;
   localparam logic [BIT_CNT_W-1:0] BITS_PER_BYTE = 4'h8;
   // Device type code; value is arbitrary
   localparam logic [3:0] DEF_TYPE_CODE = 4'h6;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_RX   = 3'h1,
      ST_ACK  = 3'h2,
      ST_TX   = 3'h3,
      ST_MACK = 3'h4,
      ST_WAIT = 3'h5
   } bus_state_t;

   typedef enum logic [1:0] {
      R_ADDR = 2'h0,
      R_WORD = 2'h1,
      R_DATA = 2'h2
   } rx_role_t;
endpackage

// ===== logic/two_wire_eeprom_slave.sv
// Two-wire serial slave front end of a 1024 x 8 nonvolatile byte memory
//
// Contract
// - Start is SDA falling while SCL high.
// - Stop is SDA rising while SCL high.
// - SDA changes only while SCL is low.
// - Ignore all bus activity until a start.
// - Stop after a read returns to standby.
// - Receiver pulls SDA low on ninth clock.
// - Ack address only on type and select match.
// - Address byte supplies two high array bits; the code takes them from write address bytes only.
// - Last address bit: one read, zero write.
// - Write takes word address then acked data.
// - Stop after write data starts programming.
// - No acknowledge while programming cycle runs.
// - Busy poll: nack while busy, ack after.
// - Page write accepts sixteen acked data bytes.
// - Write increments low four address bits only.
// - Read sends byte, continues on master ack.
// - Counter holds last address plus one.
// - SDA is open drain: pull low or release.
// - Read counter wraps across all ten bits.
`timescale 1ns/1ps
module two_wire_eeprom_slave #(
   parameter int unsigned PROG_CYCLES = eeprom_pkg::PROG_CYC,
   parameter logic [3:0]  TYPE_CODE   = eeprom_pkg::DEF_TYPE_CODE
) (
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      sda_out,
   output logic      sda_oe_n,
   input  wire logic select_strap_pin,
   input  wire logic unused_strap_low_a,
   input  wire logic unused_strap_low_b,
   output logic      write_busy
);
   localparam int unsigned AW = eeprom_pkg::ADDR_W;
   localparam int unsigned BW = eeprom_pkg::BYTE_W;
   localparam int unsigned PW = eeprom_pkg::PAGE_W;
   localparam logic [eeprom_pkg::PROG_W-1:0] PROG_LAST = eeprom_pkg::PROG_W'(PROG_CYCLES - 1);
   localparam logic [eeprom_pkg::FILT_W-1:0] FILT_LAST =
      eeprom_pkg::FILT_W'(eeprom_pkg::GLITCH_CYC - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and glitch filter

   logic [2:0] sync1_reg, sync2_reg;
   logic [1:0] filt_reg, filt_next;
   logic [1:0] prev_reg;
   logic [1:0][eeprom_pkg::FILT_W-1:0] fcnt_reg, fcnt_next;
   logic       scl_f, sda_f, scl_p, sda_p;
   logic       strap_sync;
   logic       start_det, stop_det, scl_rise, scl_fall;

   // SCL and SDA must each stay at a new level for several cycles to be taken
   always_comb begin
      filt_next = filt_reg;
      fcnt_next = fcnt_reg;
      for (int i = 0; i < 2; i++) begin
         if (sync2_reg[i] == filt_reg[i]) begin
            fcnt_next[i] = '0;
         end else if (fcnt_reg[i] == FILT_LAST) begin
            filt_next[i] = sync2_reg[i];
            fcnt_next[i] = '0;
         end else begin
            fcnt_next[i] = fcnt_reg[i] + 1'b1;
         end
      end
   end

   // Lines idle high after reset, matching the pull-ups
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sync1_reg <= 3'h7;
         sync2_reg <= 3'h7;
         filt_reg  <= 2'h3;
         prev_reg  <= 2'h3;
         fcnt_reg  <= '0;
      end else begin
         sync1_reg <= {select_strap_pin, sda_in, scl_in};
         sync2_reg <= sync1_reg;
         filt_reg  <= filt_next;
         prev_reg  <= filt_reg;
         fcnt_reg  <= fcnt_next;
      end
   end

   assign strap_sync = sync2_reg[2];
   assign scl_f      = filt_reg[0];
   assign sda_f      = filt_reg[1];
   assign scl_p      = prev_reg[0];
   assign sda_p      = prev_reg[1];
   // SDA edges with SCL high are only start or stop
   assign start_det  = scl_f && scl_p && sda_p && !sda_f;
   assign stop_det   = scl_f && scl_p && !sda_p && sda_f;
   assign scl_rise   = scl_f && !scl_p;
   assign scl_fall   = !scl_f && scl_p;

   ////////////////////////////////////////////////////////////////////////////
   // Bus state machine and programming control

   eeprom_pkg::bus_state_t state_reg, state_next;
   eeprom_pkg::rx_role_t   role_reg, role_next;
   logic [eeprom_pkg::BIT_CNT_W-1:0] cnt_reg, cnt_next;
   logic [BW-1:0] shift_reg, shift_next;
   logic [AW-1:0] addr_reg, addr_next;
   logic          rw_reg, rw_next;
   logic          oe_n_reg, oe_n_next;
   logic          mack_reg, mack_next;
   logic          wr_pending_reg, wr_pending_next;
   logic          prog_req_reg, prog_req_next;
   logic          busy_reg, busy_next;
   logic [eeprom_pkg::PROG_W-1:0] timer_reg, timer_next;
   logic          tx_load, commit, push, match, byte_done;
   logic          fifo_in_ready, fifo_out_valid, pop;
   logic [eeprom_pkg::FIFO_W-1:0] fifo_out;
   logic [BW-1:0] mem_rdata;

   assign byte_done = (state_reg == eeprom_pkg::ST_RX) && scl_fall
                      && (cnt_reg == eeprom_pkg::BITS_PER_BYTE);
   // Busy or awaiting programming: the device looks absent
   assign match = (shift_reg[7:4] == TYPE_CODE) && (shift_reg[3] == strap_sync)
                  && !busy_reg && !prog_req_reg;

   always_comb begin
      state_next      = state_reg;
      role_next       = role_reg;
      cnt_next        = cnt_reg;
      shift_next      = shift_reg;
      addr_next       = addr_reg;
      rw_next         = rw_reg;
      oe_n_next       = oe_n_reg;
      mack_next       = mack_reg;
      wr_pending_next = wr_pending_reg;
      prog_req_next   = prog_req_reg;
      busy_next       = busy_reg;
      timer_next      = timer_reg;
      tx_load         = 1'b0;
      commit          = 1'b0;
      push            = 1'b0;
      // Programming waits until the buffered page has drained
      if (prog_req_reg && !busy_reg && !fifo_out_valid) begin
         busy_next     = 1'b1;
         prog_req_next = 1'b0;
         timer_next    = PROG_LAST;
      end else if (busy_reg) begin
         if (timer_reg == '0) begin
            busy_next = 1'b0;
            commit    = 1'b1;
         end else begin
            timer_next = timer_reg - 1'b1;
         end
      end
      if (start_det) begin
         state_next = eeprom_pkg::ST_RX;
         role_next  = eeprom_pkg::R_ADDR;
         cnt_next   = '0;
         oe_n_next  = 1'b1;
      end else if (stop_det) begin
         state_next      = eeprom_pkg::ST_IDLE;
         oe_n_next       = 1'b1;
         wr_pending_next = 1'b0;
         if (wr_pending_reg) begin
            prog_req_next = 1'b1;
         end
      end else begin
         unique case (state_reg)
            eeprom_pkg::ST_IDLE, eeprom_pkg::ST_WAIT: begin
               oe_n_next = 1'b1;
            end
            eeprom_pkg::ST_RX: begin
               if (scl_rise && cnt_reg != eeprom_pkg::BITS_PER_BYTE) begin
                  shift_next = {shift_reg[BW-2:0], sda_f};
                  cnt_next   = cnt_reg + 1'b1;
               end else if (byte_done) begin
                  cnt_next   = '0;
                  state_next = eeprom_pkg::ST_ACK;
                  oe_n_next  = 1'b0;
                  unique case (role_reg)
                     eeprom_pkg::R_ADDR: begin
                        rw_next = shift_reg[0];
                        if (!match) begin
                           state_next = eeprom_pkg::ST_WAIT;
                           oe_n_next  = 1'b1;
                        end else if (!shift_reg[0]) begin
                           addr_next[AW-1:AW-2] = shift_reg[2:1];
                        end
                     end
                     eeprom_pkg::R_WORD: begin
                        addr_next = {addr_reg[AW-1:AW-2], shift_reg};
                     end
                     default: begin
                        if (fifo_in_ready) begin
                           push            = 1'b1;
                           wr_pending_next = 1'b1;
                           // Page wrap keeps the six upper bits
                           addr_next = {addr_reg[AW-1:PW], addr_reg[PW-1:0] + 1'b1};
                        end else begin
                           state_next = eeprom_pkg::ST_WAIT;
                           oe_n_next  = 1'b1;
                        end
                     end
                  endcase
               end
            end
            eeprom_pkg::ST_ACK: begin
               if (scl_fall) begin
                  if (rw_reg && role_reg == eeprom_pkg::R_ADDR) begin
                     tx_load = 1'b1;
                  end else begin
                     state_next = eeprom_pkg::ST_RX;
                     oe_n_next  = 1'b1;
                     role_next  = (role_reg == eeprom_pkg::R_ADDR) ?
                                  eeprom_pkg::R_WORD : eeprom_pkg::R_DATA;
                  end
               end
            end
            eeprom_pkg::ST_TX: begin
               if (scl_fall) begin
                  if (cnt_reg == eeprom_pkg::BITS_PER_BYTE) begin
                     state_next = eeprom_pkg::ST_MACK;
                     oe_n_next  = 1'b1;
                  end else begin
                     oe_n_next  = shift_reg[BW-2];
                     shift_next = {shift_reg[BW-2:0], 1'b0};
                     cnt_next   = cnt_reg + 1'b1;
                  end
               end
            end
            eeprom_pkg::ST_MACK: begin
               if (scl_rise) begin
                  mack_next = !sda_f;
               end else if (scl_fall) begin
                  if (mack_reg) begin
                     tx_load = 1'b1;
                  end else begin
                     state_next = eeprom_pkg::ST_WAIT;
                  end
               end
            end
            default: begin
               state_next = eeprom_pkg::ST_IDLE;
               oe_n_next  = 1'b1;
            end
         endcase
      end
      // First data bit goes out at the same SCL fall that ends the ack
      if (tx_load) begin
         state_next = eeprom_pkg::ST_TX;
         shift_next = mem_rdata;
         oe_n_next  = mem_rdata[BW-1];
         cnt_next   = 4'h1;
         mack_next  = 1'b0;
         addr_next  = addr_reg + 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_reg      <= eeprom_pkg::ST_IDLE;
         role_reg       <= eeprom_pkg::R_ADDR;
         cnt_reg        <= '0;
         shift_reg      <= '0;
         addr_reg       <= '0;
         rw_reg         <= 1'b0;
         oe_n_reg       <= 1'b1;
         mack_reg       <= 1'b0;
         wr_pending_reg <= 1'b0;
         prog_req_reg   <= 1'b0;
         busy_reg       <= 1'b0;
         timer_reg      <= '0;
      end else begin
         state_reg      <= state_next;
         role_reg       <= role_next;
         cnt_reg        <= cnt_next;
         shift_reg      <= shift_next;
         addr_reg       <= addr_next;
         rw_reg         <= rw_next;
         oe_n_reg       <= oe_n_next;
         mack_reg       <= mack_next;
         wr_pending_reg <= wr_pending_next;
         prog_req_reg   <= prog_req_next;
         busy_reg       <= busy_next;
         timer_reg      <= timer_next;
      end
   end

   // Open drain: the data driver is always low, only the enable moves
   assign sda_out    = 1'b0;
   assign sda_oe_n   = oe_n_reg;
   assign write_busy = busy_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Write buffer, page latch and array

   // Drain stalls while programming, but no byte is accepted then, so a burst cannot fill the FIFO
   byte_fifo #(
      .WIDTH (eeprom_pkg::FIFO_W),
      .DEPTH (eeprom_pkg::FIFO_DEPTH)
   ) u_wr_fifo (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   ({addr_reg, shift_reg}),
      .out_valid (fifo_out_valid),
      .out_ready (!busy_reg),
      .out_data  (fifo_out)
   );

   assign pop = fifo_out_valid && !busy_reg;

   logic [BW-1:0] mem [0:(1 << AW)-1];
   logic [BW-1:0] page_buf [0:eeprom_pkg::PAGE_BYTES-1];
   logic [eeprom_pkg::PAGE_BYTES-1:0] page_mask_reg;
   logic [AW-PW-1:0] page_base_reg;

   assign mem_rdata = mem[addr_reg];

   // A later byte to the same slot overwrites the earlier one
   always_ff @(posedge clk_sys) begin
      if (pop) begin
         page_buf[fifo_out[BW+PW-1:BW]] <= fifo_out[BW-1:0];
      end
      if (commit) begin
         for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++) begin
            if (page_mask_reg[i]) begin
               mem[{page_base_reg, PW'(i)}] <= page_buf[i];
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         page_mask_reg <= '0;
         page_base_reg <= '0;
      end else if (commit) begin
         page_mask_reg <= '0;
      end else if (pop) begin
         page_mask_reg[fifo_out[BW+PW-1:BW]] <= 1'b1;
         page_base_reg <= fifo_out[BW+AW-1:BW+PW];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   sequence s_stop_with_data;
      stop_det && wr_pending_reg;
   endsequence

   sequence s_addr_miss;
      byte_done && role_reg == eeprom_pkg::R_ADDR && !match;
   endsequence

   a_start_enters_rx: assert property (start_det |=> state_reg == eeprom_pkg::ST_RX
      && cnt_reg == '0 && oe_n_reg)
      else $error("start did not restart address reception");
   a_stop_to_idle: assert property (stop_det |=> state_reg == eeprom_pkg::ST_IDLE
      && oe_n_reg)
      else $error("stop did not return to standby");
   a_drive_scl_low: assert property ($fell(oe_n_reg) |-> !scl_f)
      else $error("SDA pulled low while SCL high");
   a_idle_silent: assert property (state_reg inside {eeprom_pkg::ST_IDLE,
      eeprom_pkg::ST_WAIT} && !$past(tx_load) |-> oe_n_reg)
      else $error("SDA driven while idle");
   a_ack_low: assert property (state_reg == eeprom_pkg::ST_ACK |-> !oe_n_reg)
      else $error("ack phase without SDA low");
   a_addr_nack: assert property (s_addr_miss |=> state_reg == eeprom_pkg::ST_WAIT
      && oe_n_reg)
      else $error("mismatched address byte acknowledged");
   a_busy_no_ack: assert property (busy_reg |-> oe_n_reg)
      else $error("SDA driven during programming");
   a_busy_holds: assert property ($rose(busy_reg) |-> busy_reg[*8])
      else $error("programming cycle ended early");
   a_prog_after_stop: assert property (s_stop_with_data |=> prog_req_reg
      ##[0:40] busy_reg)
      else $error("stop after write data did not start programming");
   a_no_prog_empty: assert property (stop_det && !wr_pending_reg && !prog_req_reg
      && !busy_reg |=> !prog_req_reg && !busy_reg)
      else $error("programming started without data");
   a_page_wrap: assert property (push |=> addr_reg[AW-1:PW] == $past(addr_reg[AW-1:PW])
      && addr_reg[PW-1:0] == $past(addr_reg[PW-1:0]) + 4'h1)
      else $error("write address left its page");
   a_read_step: assert property (tx_load |=> addr_reg == $past(addr_reg) + 10'h001
      && shift_reg == $past(mem_rdata))
      else $error("read counter or data wrong");
endmodule

// ===== tb/bus_master_model.sv
// Behavioural two-wire bus master driving SCL and pulling SDA
`timescale 1ns/1ps
module bus_master_model (
   output logic      scl,
   output logic      sda_pull,
   input  wire logic sda
);
   localparam realtime Q = 31.25;
   // Idle bus: clock parked high, data released to the pull-up
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // One bit: data moves mid-low, sampled late in the high phase
   task automatic bit_io(input logic v, output logic s);
      scl = 1'b0;
      #Q;
      sda_pull = ~v;
      #Q;
      scl = 1'b1;
      #(2*Q);
      s = sda;
   endtask
   // Start or repeated start
   task automatic start();
      scl = 1'b0;
      #Q;
      sda_pull = 1'b0;
      #Q;
      scl = 1'b1;
      #(2*Q);
      sda_pull = 1'b1;
      #(2*Q);
   endtask
   // Stop, issued once the slave has let go of SDA
   task automatic stop();
      scl = 1'b0;
      #Q;
      sda_pull = 1'b1;
      #Q;
      scl = 1'b1;
      #(2*Q);
      sda_pull = 1'b0;
      #(2*Q);
   endtask
   // Short SCL dip while high; a counted edge would shift the byte
   task automatic scl_dip(input realtime w);
      scl = 1'b0;
      #w;
      scl = 1'b1;
      #(2*Q);
   endtask
   // Byte out MSB first, then SDA released for the ninth clock
   task automatic wbyte(input logic [7:0] b, output logic ack_n);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], s);
      end
      bit_io(1'b1, ack_n);
   endtask
   // Byte in; a withheld ack on the ninth clock ends the read
   task automatic rbyte(output logic [7:0] b, input logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, b[i]);
      end
      bit_io(~ack, s);
   endtask
endmodule

// ===== tb/two_wire_eeprom_slave_tb.sv
// Self-checking bench for the two-wire serial memory slave
`timescale 1ns/1ps
module two_wire_eeprom_slave_tb;
   // Short programming time keeps the run brief
   localparam int unsigned PROG = 200;
   logic       clk_sys;
   logic       sys_rst;
   logic       scl;
   logic       sda_pull;
   logic       sda_w;
   logic       sda_out;
   logic       sda_oe_n;
   logic       strap;
   logic       write_busy;
   logic [7:0] d;
   int         num_errors = 0;
   int         samples_checked = 0;
   // Wired-AND of both open-drain drivers with the pull-up
   assign sda_w = ((~sda_oe_n & ~sda_out) | sda_pull) ? 1'b0 : 1'b1;
   two_wire_eeprom_slave #(.PROG_CYCLES(PROG)) uut (
      .clk_sys           (clk_sys),
      .sys_rst           (sys_rst),
      .scl_in            (scl),
      .sda_in            (sda_w),
      .sda_out           (sda_out),
      .sda_oe_n          (sda_oe_n),
      .select_strap_pin  (strap),
      .unused_strap_low_a(1'b0),
      .unused_strap_low_b(1'b0),
      .write_busy        (write_busy)
   );
   bus_master_model mst (
      .scl     (scl),
      .sda_pull(sda_pull),
      .sda     (sda_w)
   );
   //////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Address byte with select bit high
   function automatic logic [7:0] ab(input logic [9:0] a, input logic rd);
      return {eeprom_pkg::DEF_TYPE_CODE, 1'b1, a[9:8], rd};
   endfunction
   task automatic wr(input logic [7:0] b, input logic exp_n);
      logic a;
      mst.wbyte(b, a);
      chk({7'h0, a}, {7'h0, exp_n});
   endtask
   // Start plus write address byte plus word address
   task automatic setp(input logic [9:0] a);
      mst.start();
      wr(ab(a, 1'b0), 1'b0);
      wr(a[7:0], 1'b0);
   endtask
   // Busy must rise, refuse an address, then ack within a bounded poll
   task automatic wait_prog();
      int   n;
      logic a;
      n = 0;
      while (write_busy !== 1'b1 && n < 50) begin
         @(negedge clk_sys);
         n++;
      end
      chk({7'h0, write_busy}, 8'h01);
      mst.start();
      wr(ab(10'h000, 1'b0), 1'b1);
      mst.stop();
      n = 0;
      do begin
         mst.start();
         mst.wbyte(ab(10'h000, 1'b0), a);
         mst.stop();
         n++;
      end while (a !== 1'b0 && n < 20);
      chk({7'h0, a}, 8'h00);
   endtask
   // Wrong type code, wrong select, live strap, write without data
   task automatic t_reject();
      mst.start();
      wr({~eeprom_pkg::DEF_TYPE_CODE, 4'h8}, 1'b1);
      mst.stop();
      mst.start();
      wr({eeprom_pkg::DEF_TYPE_CODE, 4'h0}, 1'b1);
      mst.stop();
      @(negedge clk_sys);
      strap = 1'b0;
      mst.start();
      wr({eeprom_pkg::DEF_TYPE_CODE, 4'h0}, 1'b0);
      wr(8'h55, 1'b0);
      mst.stop();
      repeat (30) @(negedge clk_sys);
      chk({7'h0, write_busy}, 8'h00);
      strap = 1'b1;
      wr(ab(10'h000, 1'b0), 1'b1);
      mst.start();
      mst.scl_dip(20.0);
      wr(ab(10'h000, 1'b0), 1'b0);
      mst.stop();
      $display("test reject done");
   endtask
   // Seventeen bytes from low nibble E wrap in the page, then read back
   task automatic t_page();
      setp(10'h23E);
      for (int i = 0; i < 17; i++) begin
         wr(8'hA0 + i[7:0], 1'b0);
      end
      mst.stop();
      wait_prog();
      setp(10'h230);
      mst.start();
      wr(ab(10'h000, 1'b1), 1'b0);
      for (int k = 0; k < 16; k++) begin
         mst.rbyte(d, k < 15);
         chk(d, k == 14 ? 8'hB0 : k == 15 ? 8'hA1 : 8'hA2 + k[7:0]);
      end
      mst.stop();
      $display("test page done");
   endtask
   // Top address then counter rolls to zero for a current read
   task automatic t_wrap();
      setp(10'h000);
      wr(8'hC3, 1'b0);
      mst.stop();
      wait_prog();
      setp(10'h3FF);
      wr(8'h5A, 1'b0);
      mst.stop();
      wait_prog();
      setp(10'h3FF);
      mst.start();
      wr(ab(10'h000, 1'b1), 1'b0);
      mst.rbyte(d, 1'b0);
      chk(d, 8'h5A);
      mst.stop();
      mst.start();
      wr(ab(10'h000, 1'b1), 1'b0);
      mst.rbyte(d, 1'b0);
      chk(d, 8'hC3);
      mst.stop();
      $display("test wrap done");
   endtask
   task automatic final_report();
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   //////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Hang guard, well above the expected run length
   initial begin
      repeat (80000) @(posedge clk_sys);
      num_errors++;
      $display("ERROR %0t watchdog expired", $time);
      final_report();
   end
   initial begin
      sys_rst = 1'b1;
      strap = 1'b1;
      repeat (20) @(negedge clk_sys);
      sys_rst = 1'b0;
      repeat (10) @(negedge clk_sys);
      t_reject();
      t_page();
      t_wrap();
      final_report();
   end
endmodule
